/* File: dv/pin_board.sv */
// pin_board: board around the shared pins, pull-ups plus optional drivers
// assumes: pin vectors follow the pin level layout of pin_mux_pkg
`timescale 1ns/1ps
module pin_board
  import pin_mux_pkg::*;
(
  input  wire logic [PIN_N-1:0] pin_out,
  input  wire logic [PIN_N-1:0] pin_oe,
  input  wire logic [PIN_N-1:0] board_en,
  input  wire logic [PIN_N-1:0] board_val,
  output logic      [PIN_N-1:0] pin_in
);
  // ******************
  // wire resolution
  // ******************
  // a released line with no board driver goes to its pull-up, never keeps the last level
  assign pin_in = (pin_oe & pin_out) | (~pin_oe & board_en & board_val) | (~pin_oe & ~board_en);
endmodule // pin_board

/* File: dv/shared_pin_function_select_test.sv */
// shared_pin_function_select_test: register and pin checks of the shared pin select
// assumes: one AHB-Lite master, board model pin_board with pull-ups on all pins
`timescale 1ns/1ps
module shared_pin_function_select_test
  import pin_mux_pkg::*;
;
  logic              clk;
  logic              rst_n;
  logic              hsel;
  logic              hwrite;
  logic [31:0]       haddr;
  logic [31:0]       hwdata;
  logic [1:0]        htrans;
  logic [2:0]        hsize;
  logic              wr_low;
  logic              wr_byte;
  logic              rd_n;
  logic [TMR_N-1:0]  toggles;
  logic [CONV_N-1:0] conv_dat;
  logic [PIN_N-1:0]  board_en;
  logic [PIN_N-1:0]  board_val;
  logic [31:0]       hrdata;
  logic              hreadyout;
  logic              hresp;
  logic [CAP_N-1:0]  cap_in;
  logic [TMR_N-1:0]  tmr_in;
  logic              ws_out, ws_oe, rd_out, rd_oe;
  logic [OD_W-1:0]   od_out, od_oe;
  logic [CAP_N-1:0]  cap_out, cap_oe;
  logic [TMR_N-1:0]  tmr_out, tmr_oe;
  logic [CONV_N-1:0] conv_out, conv_oe;
  logic [PIN_N-1:0]  pin_in;
  wire logic [GP_W-1:0] gp_out = {conv_out, tmr_out, cap_out, ws_out};
  wire logic [GP_W-1:0] gp_oe  = {conv_oe, tmr_oe, cap_oe, ws_oe};
  int                num_errors = 0;
  int                comparisons = 0;

  always #20 clk = ~clk;

  shared_pin_function_select i_dut (
    .clk(clk), .rst_n(rst_n), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
    .hresp(hresp), .wr_low_strobe_n(wr_low), .wr_byte_strobe_n(wr_byte), .rd_strobe_n(rd_n),
    .timer_toggle_outputs(toggles), .converter_analog_outputs(conv_dat),
    .capture_inputs(cap_in), .timer_event_inputs(tmr_in),
    .write_strobe_shared_pin_in(pin_in[PIN_WS]), .write_strobe_shared_pin_out(ws_out),
    .write_strobe_shared_pin_oe(ws_oe), .read_strobe_pin_in(pin_in[PIN_RD]),
    .read_strobe_pin_out(rd_out), .read_strobe_pin_oe(rd_oe),
    .open_drain_port_pins_in(pin_in[PIN_OD +: OD_W]), .open_drain_port_pins_out(od_out),
    .open_drain_port_pins_oe(od_oe), .capture_shared_pins_in(pin_in[PIN_CAP +: CAP_N]),
    .capture_shared_pins_out(cap_out), .capture_shared_pins_oe(cap_oe),
    .timer_shared_pins_in(pin_in[PIN_TMR +: TMR_N]), .timer_shared_pins_out(tmr_out),
    .timer_shared_pins_oe(tmr_oe), .converter_shared_pins_in(pin_in[PIN_CONV +: CONV_N]),
    .converter_shared_pins_out(conv_out), .converter_shared_pins_oe(conv_oe)
  );

  pin_board i_board (
    .pin_out({conv_out, tmr_out, cap_out, od_out, rd_out, ws_out}),
    .pin_oe({conv_oe, tmr_oe, cap_oe, od_oe, rd_oe, ws_oe}),
    .board_en(board_en), .board_val(board_val), .pin_in(pin_in)
  );

  // ******************
  // tasks
  // ******************
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      num_errors++;
      $display("FAIL at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // address phase held until hready, then data phase until hready again
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
    @(posedge clk);
    hsel <= 1'b1;
    haddr <= {24'h000000, a};
    hwrite <= wr;
    htrans <= 2'h2;
    do @(posedge clk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge clk); while (hreadyout !== 1'b1);
    r = hrdata;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    bus(1'b1, a, d, r);
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] r;
    bus(1'b0, a, 32'h00000000, r);
    check(r, exp);
  endtask

  // pins settle one cycle after the data phase, pad levels after the synchroniser
  task automatic wait_cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  task automatic conclude();
    if (num_errors == 0 && comparisons > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  initial begin
    #200000;
    num_errors++;
    conclude();
  end

  // ******************
  // tests
  // ******************
  initial begin
    clk = 1'b0;
    rst_n = 1'b0;
    hsel = 1'b0;
    hwrite = 1'b0;
    haddr = 32'h00000000;
    hwdata = 32'h00000000;
    htrans = 2'h0;
    hsize = 3'h2;
    wr_low = 1'b0;
    wr_byte = 1'b1;
    rd_n = 1'b0;
    toggles = 3'h2;
    conv_dat = 3'h5;
    board_en = '0;
    board_val = '0;
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    wait_cyc(1);
    check(32'({gp_oe, od_oe, rd_oe}), 32'h00000000);
    wr(8'h1C, 32'hFFFFFFFF);
    rd_chk(REG_PORT_DATA, 32'h00000000);
    rd_chk(REG_PORT_DIR, 32'h00000000);
    rd_chk(REG_OD_LATCH, 32'h000000FF);
    rd_chk(REG_ANALOG_EN, 32'h00000000);
    rd_chk(REG_FUNC_CTRL, 32'h00000000);
    rd_chk(8'h1C, 32'h00000000);
    check(32'({hreadyout, hresp}), 32'h00000002);
    // port mode on every shared pin
    wr(REG_PORT_DIR, 32'h000001FF);
    wr(REG_PORT_DATA, 32'h000000A5);
    wait_cyc(2);
    check(32'(gp_out), 32'h000000A5);
    check(32'(gp_oe), 32'h000001FF);
    check(32'(rd_oe), 32'h00000000);
    // alternates on with direction cleared, 16-bit external bus
    wr(REG_PORT_DIR, 32'h00000000);
    wr(REG_FUNC_CTRL, 32'h0000037F);
    wait_cyc(2);
    check(32'(gp_out & 9'h1F9), 32'h00000150);
    check(32'(gp_oe), 32'h000001F9);
    check(32'({rd_oe, rd_out}), 32'h00000002);
    // 8-bit bus: the pin follows the single byte strobe instead
    wr(REG_FUNC_CTRL, 32'h0000017F);
    wait_cyc(2);
    check(32'(ws_out), 32'h00000001);
    @(posedge clk);
    wr_byte <= 1'b0;
    rd_n <= 1'b1;
    wait_cyc(2);
    check(32'({rd_oe, rd_out, ws_out}), 32'h00000006);
    // alternates off again: back to the port bits
    wr(REG_FUNC_CTRL, 32'h00000000);
    wr(REG_PORT_DIR, 32'h000001FF);
    wait_cyc(2);
    check(32'(gp_out), 32'h000000A5);
    check(32'(rd_oe), 32'h00000000);
    // open-drain bits, one released pin held low by the board
    wr(REG_OD_DATA, 32'h0000005A);
    board_en[PIN_OD+4] <= 1'b1;
    wait_cyc(6);
    check(32'({od_oe, od_out}), 32'h0000A500);
    rd_chk(REG_OD_DATA, 32'h0000004A);
    rd_chk(REG_OD_LATCH, 32'h0000005A);
    wr(REG_ANALOG_EN, 32'h00000010);
    rd_chk(REG_OD_DATA, 32'h0000005A);
    // capture and timer event inputs with all outputs on those pins off
    wr(REG_PORT_DIR, 32'h00000000);
    board_en[PIN_CAP +: 5] <= 5'h1F;
    board_val[PIN_CAP +: 5] <= 5'h0E;
    wait_cyc(6);
    check(32'(cap_in), 32'h00000002);
    check(32'(tmr_in), 32'h00000003);
    rd_chk(REG_PIN_LEVEL, 32'({3'h7, 3'h3, 2'h2, 8'h4A, 2'h3}));
    conclude();
  end
endmodule // shared_pin_function_select_test

/* File: hdl/pin_level_sync.sv */
// pin_level_sync: three-stage input capture for asynchronous pin levels
// assumes: inputs come from pads outside the clk domain
`timescale 1ns/1ps
module pin_level_sync
  import pin_mux_pkg::*;
(
  input  wire logic             clk,
  input  wire logic             rst_n,
  input  wire logic [PIN_N-1:0] pin_in,
  output logic      [PIN_N-1:0] level
);
  // ***********************************************************
  // per-pin synchroniser and agreement filter
  // ***********************************************************
  for (genvar i = 0; i < PIN_N; i++) begin : g_pin
    logic s1, s2, s3, lv;
    logic next_lv;
    // first stage feeds only the second one
    always_comb begin
      next_lv = (s2 == s3) ? s3 : lv;
    end
    always_ff @(posedge clk) begin
      if (!rst_n) begin
        s1 <= 1'b0;
        s2 <= 1'b0;
        s3 <= 1'b0;
        lv <= 1'b0;
      end else begin
        s1 <= pin_in[i];
        s2 <= s1;
        s3 <= s2;
        lv <= next_lv;
      end
    end
    assign level[i] = lv;
  end
endmodule // pin_level_sync

/* File: hdl/pin_mux_pkg.sv */
// pin_mux_pkg: register map, field positions, reset values and pin indices
// assumes: AHB-Lite register bus with 32-bit data, one word per register
package pin_mux_pkg;
  // ***********************************************************
  // register byte offsets
  // ***********************************************************
  localparam logic [7:0] REG_PORT_DATA   = 8'h00;
  localparam logic [7:0] REG_PORT_DIR    = 8'h04;
  localparam logic [7:0] REG_OD_DATA     = 8'h08;
  localparam logic [7:0] REG_ANALOG_EN   = 8'h0C;
  localparam logic [7:0] REG_FUNC_CTRL   = 8'h10;
  localparam logic [7:0] REG_PIN_LEVEL   = 8'h14;
  localparam logic [7:0] REG_OD_LATCH    = 8'h18;
  localparam int         ADDR_LSB        = 0;
  localparam int         ADDR_W          = 8;

  // ***********************************************************
  // port data / direction bit positions
  // ***********************************************************
  localparam int GP_WS    = 0;
  localparam int GP_CAP   = 1;
  localparam int GP_TMR   = 3;
  localparam int GP_CONV  = 6;
  localparam int GP_W     = 9;
  localparam int OD_W     = 8;
  localparam int CAP_N    = 2;
  localparam int TMR_N    = 3;
  localparam int CONV_N   = 3;

  // ***********************************************************
  // function control fields
  // ***********************************************************
  localparam int FC_WS_EN   = 0;
  localparam int FC_TMR_EN  = 1;
  localparam int FC_CONV_EN = 4;
  localparam int FC_EXT_BUS = 8;
  localparam int FC_BUS16   = 9;

  // ***********************************************************
  // pin level vector layout
  // ***********************************************************
  localparam int PIN_WS   = 0;
  localparam int PIN_RD   = 1;
  localparam int PIN_OD   = 2;
  localparam int PIN_CAP  = 10;
  localparam int PIN_TMR  = 12;
  localparam int PIN_CONV = 15;
  localparam int PIN_N    = 18;

  // ***********************************************************
  // reset values
  // ***********************************************************
  localparam logic [GP_W-1:0] RST_PORT_DATA = 9'h000;
  localparam logic [GP_W-1:0] RST_PORT_DIR  = 9'h000;
  localparam logic [OD_W-1:0] RST_OD_DATA   = 8'hFF;
  localparam logic [OD_W-1:0] RST_ANALOG_EN = 8'h00;
  localparam logic [9:0]      RST_FUNC_CTRL = 10'h000;
endpackage

/* File: hdl/shared_pin_function_select.sv */
// shared_pin_function_select: port / alternate function selection for shared pins
// assumes: strobes, toggles and converter bits come from logic on clk; pins are async
//
// Functional notes
// - write strobe pin: port bit or strobe
// - 16-bit low-byte strobe, 8-bit byte strobe
// - read strobe pin never port, bus only
// - open-drain data read returns pin level, stored data bit where analog enable set
// - open-drain pin follows stored data bit
// - timer pins: port bit or toggle output
// - converter pins: port bit or converter output
`timescale 1ns/1ps
module shared_pin_function_select
  import pin_mux_pkg::*;
(
  input  wire logic              clk,
  input  wire logic              rst_n,
  input  wire logic              hsel,
  input  wire logic [31:0]       haddr,
  input  wire logic [1:0]        htrans,
  input  wire logic              hwrite,
  input  wire logic [2:0]        hsize,
  input  wire logic [31:0]       hwdata,
  input  wire logic              hready,
  output logic      [31:0]       hrdata,
  output logic                   hreadyout,
  output logic                   hresp,
  input  wire logic              wr_low_strobe_n,
  input  wire logic              wr_byte_strobe_n,
  input  wire logic              rd_strobe_n,
  input  wire logic [TMR_N-1:0]  timer_toggle_outputs,
  input  wire logic [CONV_N-1:0] converter_analog_outputs,
  output logic [CAP_N-1:0]       capture_inputs,
  output logic [TMR_N-1:0]       timer_event_inputs,
  input  wire logic              write_strobe_shared_pin_in,
  output logic                   write_strobe_shared_pin_out,
  output logic                   write_strobe_shared_pin_oe,
  input  wire logic              read_strobe_pin_in,
  output logic                   read_strobe_pin_out,
  output logic                   read_strobe_pin_oe,
  input  wire logic [OD_W-1:0]   open_drain_port_pins_in,
  output logic      [OD_W-1:0]   open_drain_port_pins_out,
  output logic      [OD_W-1:0]   open_drain_port_pins_oe,
  input  wire logic [CAP_N-1:0]  capture_shared_pins_in,
  output logic      [CAP_N-1:0]  capture_shared_pins_out,
  output logic      [CAP_N-1:0]  capture_shared_pins_oe,
  input  wire logic [TMR_N-1:0]  timer_shared_pins_in,
  output logic      [TMR_N-1:0]  timer_shared_pins_out,
  output logic      [TMR_N-1:0]  timer_shared_pins_oe,
  input  wire logic [CONV_N-1:0] converter_shared_pins_in,
  output logic      [CONV_N-1:0] converter_shared_pins_out,
  output logic      [CONV_N-1:0] converter_shared_pins_oe
);
  // ***********************************************************
  // state
  // ***********************************************************
  logic [GP_W-1:0]   port_data, next_port_data;
  logic [GP_W-1:0]   port_dir, next_port_dir;
  logic [OD_W-1:0]   od_data, next_od_data;
  logic [OD_W-1:0]   analog_input_enable_bits, next_analog_input_enable_bits;
  logic [9:0]        func_ctrl, next_func_ctrl;
  logic              wr_pend, next_wr_pend;
  logic [ADDR_W-1:0] wr_addr, next_wr_addr;
  logic [31:0]       next_hrdata;
  logic [PIN_N-1:0]  pin_in, level, pin_out, pin_oe, next_out, next_oe;
  logic              rd_req;

  assign pin_in = {converter_shared_pins_in, timer_shared_pins_in, capture_shared_pins_in,
                   open_drain_port_pins_in, read_strobe_pin_in, write_strobe_shared_pin_in};

  pin_level_sync u_sync (
    .clk    (clk),
    .rst_n  (rst_n),
    .pin_in (pin_in),
    .level  (level)
  );

  assign capture_inputs     = level[PIN_CAP +: CAP_N];
  assign timer_event_inputs = level[PIN_TMR +: TMR_N];

  // ***********************************************************
  // register bus: zero wait states, write lands in data phase
  // ***********************************************************
  always_comb begin
    next_port_data = port_data;
    next_port_dir  = port_dir;
    next_od_data   = od_data;
    next_analog_input_enable_bits = analog_input_enable_bits;
    next_func_ctrl = func_ctrl;
    if (wr_pend) begin
      unique case (wr_addr)
        REG_PORT_DATA: next_port_data = hwdata[GP_W-1:0];
        REG_PORT_DIR:  next_port_dir  = hwdata[GP_W-1:0];
        REG_OD_DATA:   next_od_data   = hwdata[OD_W-1:0];
        REG_ANALOG_EN: next_analog_input_enable_bits = hwdata[OD_W-1:0];
        REG_FUNC_CTRL: next_func_ctrl = hwdata[9:0];
        default: ;
      endcase
    end
    next_wr_pend = hsel && hready && htrans[1] && hwrite;
    next_wr_addr = haddr[ADDR_LSB +: ADDR_W];
    rd_req       = hsel && hready && htrans[1] && !hwrite;
    // read data from next values so a read just after a write sees it
    next_hrdata  = 32'h0000_0000;
    if (rd_req) begin
      unique case (haddr[ADDR_LSB +: ADDR_W])
        REG_PORT_DATA: next_hrdata[GP_W-1:0] = next_port_data;
        REG_PORT_DIR:  next_hrdata[GP_W-1:0] = next_port_dir;
        REG_OD_DATA: begin
          for (int i = 0; i < OD_W; i++) begin
            next_hrdata[i] = next_analog_input_enable_bits[i] ? next_od_data[i]
                                                              : level[PIN_OD+i];
          end
        end
        REG_ANALOG_EN: next_hrdata[OD_W-1:0] = next_analog_input_enable_bits;
        REG_FUNC_CTRL: next_hrdata[9:0] = next_func_ctrl;
        REG_PIN_LEVEL: next_hrdata[PIN_N-1:0] = level;
        // read-modify-write sequences read the latch, not the pin
        REG_OD_LATCH:  next_hrdata[OD_W-1:0] = next_od_data;
        default: ;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      port_data <= RST_PORT_DATA;
      port_dir  <= RST_PORT_DIR;
      od_data   <= RST_OD_DATA;
      analog_input_enable_bits <= RST_ANALOG_EN;
      func_ctrl <= RST_FUNC_CTRL;
      wr_pend   <= 1'b0;
      wr_addr   <= 8'h00;
      hrdata    <= 32'h0000_0000;
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end else begin
      port_data <= next_port_data;
      port_dir  <= next_port_dir;
      od_data   <= next_od_data;
      analog_input_enable_bits <= next_analog_input_enable_bits;
      func_ctrl <= next_func_ctrl;
      wr_pend   <= next_wr_pend;
      wr_addr   <= next_wr_addr;
      hrdata    <= next_hrdata;
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end
  end

  // ***********************************************************
  // pin drive selection, registered to the pads
  // ***********************************************************
  always_comb begin
    // write strobe pin
    if (func_ctrl[FC_WS_EN]) begin
      next_oe[PIN_WS]  = 1'b1;
      next_out[PIN_WS] = func_ctrl[FC_BUS16] ? wr_low_strobe_n : wr_byte_strobe_n;
    end else begin
      next_oe[PIN_WS]  = port_dir[GP_WS];
      next_out[PIN_WS] = port_data[GP_WS];
    end
    // read strobe pin: released outside bus modes, no port function
    next_oe[PIN_RD]  = func_ctrl[FC_EXT_BUS];
    next_out[PIN_RD] = func_ctrl[FC_EXT_BUS] ? rd_strobe_n : 1'b1;
    // open-drain pins: low when data is 0, released when 1
    for (int i = 0; i < OD_W; i++) begin
      next_out[PIN_OD+i] = 1'b0;
      next_oe[PIN_OD+i]  = !od_data[i];
    end
    // capture pins: port function only, input always sampled
    for (int i = 0; i < CAP_N; i++) begin
      next_out[PIN_CAP+i] = port_data[GP_CAP+i];
      next_oe[PIN_CAP+i]  = port_dir[GP_CAP+i];
    end
    for (int i = 0; i < TMR_N; i++) begin
      next_out[PIN_TMR+i] = func_ctrl[FC_TMR_EN+i] ? timer_toggle_outputs[i] : port_data[GP_TMR+i];
      next_oe[PIN_TMR+i]  = func_ctrl[FC_TMR_EN+i] | port_dir[GP_TMR+i];
    end
    for (int i = 0; i < CONV_N; i++) begin
      next_out[PIN_CONV+i] = func_ctrl[FC_CONV_EN+i] ? converter_analog_outputs[i]
                                                     : port_data[GP_CONV+i];
      next_oe[PIN_CONV+i]  = func_ctrl[FC_CONV_EN+i] | port_dir[GP_CONV+i];
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      // pads released; levels match what the reset registers select, so no false step after reset
      pin_out <= 18'h00002;
      pin_oe  <= 18'h00000;
    end else begin
      pin_out <= next_out;
      pin_oe  <= next_oe;
    end
  end

  assign write_strobe_shared_pin_out = pin_out[PIN_WS];
  assign write_strobe_shared_pin_oe  = pin_oe[PIN_WS];
  assign read_strobe_pin_out         = pin_out[PIN_RD];
  assign read_strobe_pin_oe          = pin_oe[PIN_RD];
  assign open_drain_port_pins_out    = pin_out[PIN_OD +: OD_W];
  assign open_drain_port_pins_oe     = pin_oe[PIN_OD +: OD_W];
  assign capture_shared_pins_out     = pin_out[PIN_CAP +: CAP_N];
  assign capture_shared_pins_oe      = pin_oe[PIN_CAP +: CAP_N];
  assign timer_shared_pins_out       = pin_out[PIN_TMR +: TMR_N];
  assign timer_shared_pins_oe        = pin_oe[PIN_TMR +: TMR_N];
  assign converter_shared_pins_out   = pin_out[PIN_CONV +: CONV_N];
  assign converter_shared_pins_oe    = pin_oe[PIN_CONV +: CONV_N];

  // ***********************************************************
  // checks
  // ***********************************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  property p_ws_port;
    !func_ctrl[FC_WS_EN] |=> write_strobe_shared_pin_oe == $past(port_dir[GP_WS])
                           && write_strobe_shared_pin_out == $past(port_data[GP_WS]);
  endproperty
  a_ws_port: assert property (p_ws_port) else $error("write strobe pin not on port bit");

  property p_ws_mode;
    func_ctrl[FC_WS_EN] |=> write_strobe_shared_pin_out ==
      ($past(func_ctrl[FC_BUS16]) ? $past(wr_low_strobe_n) : $past(wr_byte_strobe_n));
  endproperty
  a_ws_mode: assert property (p_ws_mode) else $error("wrong strobe for bus width");

  property p_rd_strobe;
    ##1 read_strobe_pin_oe == $past(func_ctrl[FC_EXT_BUS])
      && (!read_strobe_pin_oe || read_strobe_pin_out == $past(rd_strobe_n));
  endproperty
  a_rd_strobe: assert property (p_rd_strobe) else $error("read strobe pin misdriven");

  property p_od_read;
    (rd_req && !wr_pend && haddr[ADDR_LSB +: ADDR_W] == REG_OD_DATA && analog_input_enable_bits[0])
      == 1'b0 && rd_req && !wr_pend && haddr[ADDR_LSB +: ADDR_W] == REG_OD_DATA
      |=> hrdata[0] == $past(level[PIN_OD]);
  endproperty
  a_od_read: assert property (p_od_read) else $error("open-drain read not pin level");

  property p_od_drive;
    ##1 open_drain_port_pins_out == 8'h00 && open_drain_port_pins_oe == ~$past(od_data);
  endproperty
  a_od_drive: assert property (p_od_drive) else $error("open-drain pin not from data");

  property p_tmr_out;
    func_ctrl[FC_TMR_EN] ##1 func_ctrl[FC_TMR_EN]
      |-> timer_shared_pins_oe[0] && timer_shared_pins_out[0] == $past(timer_toggle_outputs[0]);
  endproperty
  a_tmr_out: assert property (p_tmr_out) else $error("timer toggle not on pin");

  property p_conv_port;
    !func_ctrl[FC_CONV_EN+2] |=> converter_shared_pins_out[2] == $past(port_data[GP_CONV+2])
                               && converter_shared_pins_oe[2] == $past(port_dir[GP_CONV+2]);
  endproperty
  a_conv_port: assert property (p_conv_port) else $error("converter pin not on port bit");

  property p_priority;
    func_ctrl[FC_CONV_EN] && !port_dir[GP_CONV] |=> converter_shared_pins_oe[0]
      && converter_shared_pins_out[0] == $past(converter_analog_outputs[0]);
  endproperty
  a_priority: assert property (p_priority) else $error("port bits override alternate output");
endmodule // shared_pin_function_select
